/* File: src/ptsm_defs.svh */
// offsets, field positions, reset values and timing counts of the
// phase timing and sag monitor; assumes a 100 MHz system clock
//
// How it works
// - one set of three delays at a time, picked by delay_set_select.
// - delays start and stop on rising voltage or current zero crossings.
// - select 00 measures voltage to current delay of phases A, B, C.
// - select 01 stores voltage delays A-C, B-C, A-B in registers 0, 1, 2.
// - select 10 stores current delays A-C, B-C, A-B in registers 0, 1, 2.
// - each delay is a 16-bit count of 256 kHz ticks.
// - period_source_select picks the voltage phase for the line period.
// - line period is a 16-bit tick count refreshed every line period.
// - stored period equals ticks in one line period minus one.
// - sag when a phase stays below threshold; phase marked in bits 14:12.
// - sag flag set after the Nth half cycle below; zero is invalid.
// - sag sets status bit 16 and, if masked in, pulls interrupt low.
// - writing status bit 16 as one clears flag, phase bits, interrupt.
// - a later sag on another phase replaces the old phase bit.
// - half-cycle counter runs unless threshold is zero or one or cycle count is zero; writing the cycle count resets it.
// - threshold meets absolute filtered voltage; full scale always trips.
// - threshold of zero or one means no sag is ever raised.
// - 24-bit threshold reads as a 32-bit word, upper byte zero.
// - voltage channels below a tenth of full scale give no crossings.
`ifndef PTSM_DEFS_SVH
`define PTSM_DEFS_SVH

// register word offsets, matched against address bits 7:2
`define PTSM_OFS_DLY0 6'h00
`define PTSM_OFS_DLY1 6'h01
`define PTSM_OFS_DLY2 6'h02
`define PTSM_OFS_PER 6'h03
`define PTSM_OFS_THR 6'h04
`define PTSM_OFS_CYC 6'h05
`define PTSM_OFS_STAT 6'h06
`define PTSM_OFS_MASK 6'h07
`define PTSM_OFS_PHST 6'h08
`define PTSM_OFS_COMP 6'h09
`define PTSM_OFS_MEAS 6'h0A

// field positions
`define PTSM_SAG_BIT 16
`define PTSM_VPH_LSB 12
`define PTSM_DSEL_LSB 9
`define PTSM_PSEL_LSB 0

// field encodings and reset values
`define PTSM_DSEL_VV 2'h1
`define PTSM_DSEL_II 2'h2
`define PTSM_DSEL_RST 2'h0
`define PTSM_PSEL_RST 2'h0
`define PTSM_THR_RST 24'h000000
`define PTSM_CYC_RST 8'h01
`define PTSM_CNT_MAX 16'hFFFF

// time base: 256 kHz from 100 MHz by fractional accumulation
`define PTSM_CLK_HZ 100000000
`define PTSM_TB_HZ 256000
`define PTSM_TB_GCD 32000
`define PTSM_TB_INC (`PTSM_TB_HZ / `PTSM_TB_GCD)
`define PTSM_TB_MOD (`PTSM_CLK_HZ / `PTSM_TB_GCD)

`endif

/* File: src/ptsm_pkg.sv */
// types of the phase timing and sag monitor
// assumes the constants of ptsm_defs.svh
package ptsm_pkg;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } ptsm_wb_req_t;

  typedef struct packed {
    logic [2:0] v_rise;
    logic [2:0] i_rise;
    logic [2:0] v_any;
    logic [2:0] v_live;
  } ptsm_zx_t;

  typedef struct packed {
    logic [11:0] tb_acc;
    logic tick;
    logic [2:0][15:0] dly;
    logic [2:0][15:0] dcnt;
    logic [2:0] arm;
    logic [15:0] per;
    logic [15:0] pcnt;
    logic pseen;
    logic [23:0] thr;
    logic [7:0] cyc;
    logic [2:0][7:0] hc;
    logic [2:0] below;
    logic sag;
    logic [2:0] vph;
    logic mask;
    logic [1:0] dsel;
    logic [1:0] psel;
    logic ack;
    logic [31:0] rdat;
    logic irq_n;
  } ptsm_state_t;

endpackage : ptsm_pkg

/* File: src/ptsm_top.sv */
// phase delay, line period and voltage sag monitor with wishbone slave
// assumes crossing strobes and voltage samples come from mclk logic
//
// Our own choices: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "ptsm_defs.svh"

module ptsm_top (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // wishbone classic slave
  input wire ptsm_pkg::ptsm_wb_req_t wb_req,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  // crossing strobes and absolute filtered voltages
  input wire ptsm_pkg::ptsm_zx_t zx,
  input wire logic v_smp,
  input wire logic [2:0][23:0] v_abs,
  // interrupt
  output logic event_interrupt_n
);

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // start and stop strobes of delay pair k for a select value
  function automatic logic [1:0] ptsm_pair(
    input logic [1:0] sel,
    input logic [2:0] vr,
    input logic [2:0] ir,
    input int k
  );
    logic [2:0] src;
    logic [1:0] r;
    src = (sel == `PTSM_DSEL_VV) ? vr : ir;
    if (sel == `PTSM_DSEL_VV || sel == `PTSM_DSEL_II)
    begin
      r = {src[(k == 1) ? 1 : 0], src[(k == 2) ? 1 : 2]};
    end
    else
    begin
      r = {vr[k], ir[k]};
    end
    return r;
  endfunction : ptsm_pair

  // byte lane merge of a write
  function automatic logic [31:0] ptsm_merge(
    input logic [31:0] old,
    input logic [31:0] din,
    input logic [3:0] sel
  );
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        r[8*i +: 8] = din[8*i +: 8];
      end
    end
    return r;
  endfunction : ptsm_merge

  ////////////////////////////////////////////////////////////////////////
  // state

  ptsm_pkg::ptsm_state_t st_r;
  ptsm_pkg::ptsm_state_t st_nxt;

  logic [12:0] acc_sum;
  logic [2:0] vr;
  logic [2:0] va;
  logic [23:0] thr_eff;
  logic [2:0] sag_set;
  logic [2:0] dcap;
  logic per_upd;
  logic stat_clr;
  logic cyc_wr;
  logic acc_go;
  logic [5:0] idx;
  logic [31:0] rmux;
  logic [31:0] wv;
  logic [1:0] pr;
  logic [1:0] ps;
  logic pe;

  assign wb_ack_o = st_r.ack;
  assign wb_dat_o = st_r.rdat;
  assign event_interrupt_n = st_r.irq_n;

  ////////////////////////////////////////////////////////////////////////
  // register read view

  always_comb
  begin
    idx = wb_req.adr[7:2];
    rmux = 32'h00000000;
    unique case (idx)
      `PTSM_OFS_DLY0: rmux[15:0] = st_r.dly[0];
      `PTSM_OFS_DLY1: rmux[15:0] = st_r.dly[1];
      `PTSM_OFS_DLY2: rmux[15:0] = st_r.dly[2];
      `PTSM_OFS_PER: rmux[15:0] = st_r.per;
      `PTSM_OFS_THR: rmux[23:0] = st_r.thr;
      `PTSM_OFS_CYC: rmux[7:0] = st_r.cyc;
      `PTSM_OFS_STAT: rmux[`PTSM_SAG_BIT] = st_r.sag;
      `PTSM_OFS_MASK: rmux[`PTSM_SAG_BIT] = st_r.mask;
      `PTSM_OFS_PHST: rmux[`PTSM_VPH_LSB +: 3] = st_r.vph;
      `PTSM_OFS_COMP: rmux[`PTSM_DSEL_LSB +: 2] = st_r.dsel;
      `PTSM_OFS_MEAS: rmux[`PTSM_PSEL_LSB +: 2] = st_r.psel;
      default: rmux = 32'h00000000;
    endcase
    wv = ptsm_merge(rmux, wb_req.dat, wb_req.sel);
  end

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    st_nxt = st_r;
    sag_set = 3'h0;
    dcap = 3'h0;
    per_upd = 1'b0;
    stat_clr = 1'b0;
    cyc_wr = 1'b0;
    pr = 2'h0;
    ps = 2'h0;
    pe = 1'b0;
    acc_go = wb_req.cyc & wb_req.stb & ~st_r.ack;

    // 256 kHz tick
    acc_sum = {1'b0, st_r.tb_acc} + 13'(`PTSM_TB_INC);
    st_nxt.tick = 1'b0;
    if (acc_sum >= 13'(`PTSM_TB_MOD))
    begin
      acc_sum = acc_sum - 13'(`PTSM_TB_MOD);
      st_nxt.tick = 1'b1;
    end
    st_nxt.tb_acc = acc_sum[11:0];

    // quiet voltage channels give no crossings
    vr = zx.v_rise & zx.v_live;
    va = zx.v_any & zx.v_live;

    // delays between rising crossings
    for (int k = 0; k < 3; k++)
    begin
      pr = ptsm_pair(st_r.dsel, vr, zx.i_rise, k);
      if (pr[0] && st_r.arm[k])
      begin
        st_nxt.dly[k] = st_r.dcnt[k];
        st_nxt.arm[k] = 1'b0;
        dcap[k] = 1'b1;
      end
      if (pr[1])
      begin
        st_nxt.dcnt[k] = 16'h0000;
        st_nxt.arm[k] = 1'b1;
      end
      else if (st_r.tick && st_r.arm[k] && st_r.dcnt[k] != `PTSM_CNT_MAX)
      begin
        st_nxt.dcnt[k] = st_r.dcnt[k] + 16'h0001;
      end
    end

    // line period on the selected voltage
    ps = (st_r.psel == 2'h3) ? 2'h0 : st_r.psel;
    pe = vr[ps];
    if (pe)
    begin
      if (st_r.pseen && (st_r.pcnt != 16'h0000 || st_r.tick))
      begin
        // a tick on the crossing edge closes the old period
        st_nxt.per = st_r.pcnt + 16'(st_r.tick) - 16'h0001;
        per_upd = 1'b1;
      end
      st_nxt.pcnt = 16'h0000;
      st_nxt.pseen = 1'b1;
    end
    else if (st_r.tick && st_r.pcnt != `PTSM_CNT_MAX)
    begin
      st_nxt.pcnt = st_r.pcnt + 16'h0001;
    end

    // sag: levels of zero or one disable detection
    thr_eff = (st_r.thr <= 24'h000001) ? 24'h000000 : st_r.thr;
    for (int p = 0; p < 3; p++)
    begin
      if (v_smp && v_abs[p] >= thr_eff)
      begin
        st_nxt.below[p] = 1'b0;
      end
      if (va[p])
      begin
        st_nxt.below[p] = 1'b1;
        if (st_nxt.below[p] == st_r.below[p] && st_r.below[p] &&
            !(v_smp && v_abs[p] >= thr_eff) &&
            thr_eff != 24'h000000 && st_r.cyc != 8'h00)
        begin
          if (st_r.hc[p] + 8'h01 >= st_r.cyc)
          begin
            sag_set[p] = 1'b1;
            st_nxt.hc[p] = 8'h00;
          end
          else
          begin
            st_nxt.hc[p] = st_r.hc[p] + 8'h01;
          end
        end
        else
        begin
          st_nxt.hc[p] = 8'h00;
        end
      end
    end

    // bus access
    st_nxt.ack = acc_go;
    if (acc_go && !wb_req.we)
    begin
      st_nxt.rdat = rmux;
    end
    if (acc_go && wb_req.we)
    begin
      unique case (idx)
        `PTSM_OFS_THR: st_nxt.thr = wv[23:0];
        `PTSM_OFS_CYC:
        begin
          st_nxt.cyc = wv[7:0];
          cyc_wr = 1'b1;
        end
        `PTSM_OFS_STAT:
          stat_clr = wb_req.sel[2] & wb_req.dat[`PTSM_SAG_BIT];
        `PTSM_OFS_MASK: st_nxt.mask = wv[`PTSM_SAG_BIT];
        `PTSM_OFS_COMP:
        begin
          st_nxt.dsel = wv[`PTSM_DSEL_LSB +: 2];
          st_nxt.arm = 3'h0;
        end
        `PTSM_OFS_MEAS:
        begin
          st_nxt.psel = wv[`PTSM_PSEL_LSB +: 2];
          st_nxt.pseen = 1'b0;
        end
        default: st_nxt.rdat = st_r.rdat;
      endcase
    end

    // writing the cycle count restarts the half-cycle window
    if (cyc_wr)
    begin
      st_nxt.hc = '0;
      st_nxt.below = 3'h7;
      sag_set = 3'h0;
    end

    // sag flag and phase bits, set wins over clear
    if (sag_set != 3'h0)
    begin
      st_nxt.sag = 1'b1;
      st_nxt.vph = sag_set;
    end
    else if (stat_clr)
    begin
      st_nxt.sag = 1'b0;
      st_nxt.vph = 3'h0;
    end
    st_nxt.irq_n = ~(st_nxt.sag & st_nxt.mask);
  end

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_r <= '0;
      st_r.below <= 3'h7;
      st_r.thr <= `PTSM_THR_RST;
      st_r.cyc <= `PTSM_CYC_RST;
      st_r.dsel <= `PTSM_DSEL_RST;
      st_r.psel <= `PTSM_PSEL_RST;
      st_r.irq_n <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  property p_irq_follows_sag;
    !event_interrupt_n == (st_r.sag & st_r.mask);
  endproperty
  a_irq_follows_sag: assert property (p_irq_follows_sag)
    else $error("interrupt does not match sag flag and mask");

  property p_clear_sag;
    (stat_clr && sag_set == 3'h0) |=> (!st_r.sag && st_r.vph == 3'h0);
  endproperty
  a_clear_sag: assert property (p_clear_sag)
    else $error("status write did not clear sag");

  property p_set_sag;
    (sag_set != 3'h0) |=> (st_r.sag && st_r.vph == $past(sag_set)
      && (st_r.irq_n != st_r.mask));
  endproperty
  a_set_sag: assert property (p_set_sag)
    else $error("sag set did not mark phase");

  property p_no_sag_low_thr;
    (sag_set != 3'h0) |-> (st_r.thr > 24'h000001);
  endproperty
  a_no_sag_low_thr: assert property (p_no_sag_low_thr)
    else $error("sag raised with threshold zero or one");

  property p_period_minus_one;
    per_upd |=> (st_r.per ==
      $past(st_r.pcnt) + 16'($past(st_r.tick)) - 16'h0001);
  endproperty
  a_period_minus_one: assert property (p_period_minus_one)
    else $error("period not ticks minus one");

  property p_delay_armed;
    (dcap != 3'h0) |-> ((dcap & ~st_r.arm) == 3'h0);
  endproperty
  a_delay_armed: assert property (p_delay_armed)
    else $error("delay captured without start");

  property p_cyc_reset;
    cyc_wr |=> (st_r.hc == '0);
  endproperty
  a_cyc_reset: assert property (p_cyc_reset)
    else $error("cycle count write did not reset counter");

  property p_cyc_nonzero;
    (sag_set != 3'h0) |-> (st_r.cyc != 8'h00);
  endproperty
  a_cyc_nonzero: assert property (p_cyc_nonzero)
    else $error("sag raised with zero cycle count");

  property p_ack_pulse;
    st_r.ack |=> !st_r.ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack held longer than one cycle");

  property p_dead_no_hc;
    (!zx.v_live[0] && !cyc_wr) |=> $stable(st_r.hc[0]);
  endproperty
  a_dead_no_hc: assert property (p_dead_no_hc)
    else $error("half-cycle count moved on a quiet channel");

  property p_period_hold;
    !per_upd |=> $stable(st_r.per);
  endproperty
  a_period_hold: assert property (p_period_hold)
    else $error("period changed without a selected crossing");

  property p_delay_hold;
    !dcap[0] |=> $stable(st_r.dly[0]);
  endproperty
  a_delay_hold: assert property (p_delay_hold)
    else $error("delay changed without a stop crossing");

  property p_thr_upper_zero;
    (acc_go && !wb_req.we && idx == `PTSM_OFS_THR) |=>
      (wb_dat_o[31:24] == 8'h00);
  endproperty
  a_thr_upper_zero: assert property (p_thr_upper_zero)
    else $error("threshold read with nonzero upper byte");

endmodule : ptsm_top
`default_nettype wire

/* File: testbench/tb_phase_timing_and_sag_monitor.sv */
// self-checking bench for the phase timing and sag monitor
// drives wishbone cycles and crossing strobes; assertions sit in the design
`timescale 1ns/1ps
`default_nettype none
`include "ptsm_defs.svh"

module tb_phase_timing_and_sag_monitor;
  logic mclk;
  logic rstn;
  ptsm_pkg::ptsm_wb_req_t wb_req;
  logic wb_ack_o;
  logic [31:0] wb_dat_o;
  ptsm_pkg::ptsm_zx_t zx;
  logic v_smp;
  logic [2:0][23:0] v_abs;
  logic event_interrupt_n;
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [31:0] rd_q;
  logic [5:0] st;
  logic [5:0] sp;
  int w;

  ptsm_top u_dut (
    .mclk(mclk),
    .rstn(rstn),
    .wb_req(wb_req),
    .wb_ack_o(wb_ack_o),
    .wb_dat_o(wb_dat_o),
    .zx(zx),
    .v_smp(v_smp),
    .v_abs(v_abs),
    .event_interrupt_n(event_interrupt_n)
  );

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic results;
    if (errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : results

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 70000)
    begin
      errors++;
      results();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one classic cycle, held until ack is sampled high
  task automatic wb(input logic we, input logic [5:0] idx,
                    input logic [31:0] d);
    int n;
    @(posedge mclk);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {idx, 2'b00},
                sel: 4'hF, dat: d};
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 50);
    rd_q = wb_dat_o;
    wb_req <= '0;
    if (n >= 50)
    begin
      errors++;
      $display("BAD %0t no ack", $time);
    end
  endtask : wb

  task automatic rd(input logic [5:0] idx, input logic [31:0] exp);
    wb(1'b0, idx, 32'h00000000);
    chk(rd_q, exp);
  endtask : rd

  // one-cycle strobes, mask is {v_any, i_rise, v_rise}
  task automatic zp(input logic [8:0] m);
    @(posedge mclk);
    {zx.v_any, zx.i_rise, zx.v_rise} <= m;
    @(posedge mclk);
    {zx.v_any, zx.i_rise, zx.v_rise} <= 9'h000;
  endtask : zp

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rstn = 1'b0;
    wb_req = '0;
    zx = '0;
    zx.v_live = 3'h7;
    v_smp = 1'b1;
    v_abs = {3{24'h000010}};
    repeat (8) @(posedge mclk);
    rstn <= 1'b1;
    rd(`PTSM_OFS_THR, 32'h00000000);
    rd(`PTSM_OFS_DLY0, 32'h00000000);
    rd(6'h3F, 32'h00000000);
    wb(1'b1, `PTSM_OFS_DLY0, 32'hFFFFFFFF);
    rd(`PTSM_OFS_DLY0, 32'h00000000);
    wb(1'b1, `PTSM_OFS_THR, 32'hFFFFFFFF);
    rd(`PTSM_OFS_THR, 32'h00FFFFFF);
    // delay sets: distinct gaps per register expose a wrong mapping
    for (int s = 0; s < 4; s++)
    begin
      wb(1'b1, `PTSM_OFS_COMP, 32'(s) << `PTSM_DSEL_LSB);
      for (int k = 0; k < 3; k++)
      begin
        st = (k == 1) ? 6'h02 : 6'h01;
        sp = (k == 2) ? 6'h02 : 6'h04;
        if (s == 2)
        begin
          st = st << 3;
          sp = sp << 3;
        end
        else if (s != 1)
        begin
          st = 6'h01 << k;
          sp = 6'h08 << k;
        end
        w = 700 * (k + 1) + 800 * s;
        zp({3'h0, st});
        repeat (w - 2) @(posedge mclk);
        zp({3'h0, sp});
        repeat (2) @(posedge mclk);
        wb(1'b0, 6'(k), 32'h00000000);
        total_checks++;
        if (rd_q !== 32'(w * 8 / 3125) && rd_q !== 32'(w * 8 / 3125 + 1))
        begin
          errors++;
          $display("BAD %0t delay %0d sel %0d got %h", $time, k, s, rd_q);
        end
      end
    end
    // period over exactly 16 ticks on each source phase
    for (int p = 0; p < 3; p++)
    begin
      wb(1'b1, `PTSM_OFS_MEAS, 32'(p));
      zp(9'h001 << p);
      repeat (6248) @(posedge mclk);
      zp(9'h001 << p);
      repeat (2) @(posedge mclk);
      rd(`PTSM_OFS_PER, 32'h0000000F);
    end
    // sag at full-scale threshold on phase A, then phase B
    wb(1'b1, `PTSM_OFS_THR, 32'h005A7540);
    wb(1'b1, `PTSM_OFS_CYC, 32'h00000002);
    wb(1'b1, `PTSM_OFS_MASK, 32'h00010000);
    zp(9'h040);
    repeat (2) @(posedge mclk);
    chk(32'(event_interrupt_n), 32'h1);
    repeat (2) zp(9'h040);
    repeat (2) @(posedge mclk);
    chk(32'(event_interrupt_n), 32'h0);
    rd(`PTSM_OFS_STAT, 32'h00010000);
    rd(`PTSM_OFS_PHST, 32'h00001000);
    repeat (3) zp(9'h080);
    repeat (2) @(posedge mclk);
    rd(`PTSM_OFS_PHST, 32'h00002000);
    rd(`PTSM_OFS_STAT, 32'h00010000);
    wb(1'b1, `PTSM_OFS_STAT, 32'h00010000);
    rd(`PTSM_OFS_STAT, 32'h00000000);
    rd(`PTSM_OFS_PHST, 32'h00000000);
    chk(32'(event_interrupt_n), 32'h1);
    // cycle-count write restarts the window
    zp(9'h100);
    wb(1'b1, `PTSM_OFS_CYC, 32'h00000002);
    zp(9'h100);
    repeat (2) @(posedge mclk);
    chk(32'(event_interrupt_n), 32'h1);
    // quiet phase A gives no half-cycle count
    zx.v_live <= 3'h6;
    repeat (2) zp(9'h040);
    repeat (2) @(posedge mclk);
    chk(32'(event_interrupt_n), 32'h1);
    zx.v_live <= 3'h7;
    // threshold of one never trips, even with zero voltage
    v_abs <= '0;
    wb(1'b1, `PTSM_OFS_THR, 32'h00000001);
    wb(1'b1, `PTSM_OFS_CYC, 32'h00000002);
    repeat (4) zp(9'h040);
    repeat (2) @(posedge mclk);
    rd(`PTSM_OFS_STAT, 32'h00000000);
    chk(32'(event_interrupt_n), 32'h1);
    results();
  end
endmodule : tb_phase_timing_and_sag_monitor
`default_nettype wire
